// ### core/scl_pkg.sv
package scl_pkg;
  // register indexes; the bus byte address is four times the index
  localparam logic [7:0] IDX_CHIP_ID = 8'h20;
  localparam logic [7:0] IDX_CFG1 = 8'h21;
  localparam logic [7:0] IDX_CFG2 = 8'h22;
  localparam logic [7:0] IDX_CFG3 = 8'h23;
  localparam logic [7:0] IDX_CFG4 = 8'h24;
  localparam logic [7:0] IDX_CFG5 = 8'h25;
  localparam logic [7:0] IDX_REV = 8'h27;
  localparam logic [7:0] IDX_CFG8 = 8'h28;
  localparam logic [7:0] IDX_CFGA = 8'h2A;
  localparam logic [7:0] IDX_CFGB = 8'h2B;
  localparam logic [7:0] IDX_CFGC = 8'h2C;
  localparam logic [7:0] IDX_CFGD = 8'h2D;
  localparam logic [7:0] IDX_STATUS = 8'h30;
  localparam logic [7:0] IDX_SYSCTL = 8'h31;
  // identity values are arbitrary
  localparam logic [7:0] CHIP_ID_VAL = 8'h5A;
  localparam logic [7:0] CHIP_REV_VAL = 8'h01;
  // reset values
  localparam logic [7:0] CFG1_RST = 8'h11;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] CFGD_RST = 8'h01;
  // field positions
  localparam int D_MODE_BIT = 0;
  localparam int D_TMO_LO = 3;
  localparam int D_POL_BIT = 7;
  localparam int B_LMODE_LO = 2;
  localparam int C_LED1_LO = 0;
  localparam int C_LED2_LO = 3;
  localparam int C_S5SW_BIT = 6;
  localparam int A_LED1_LO = 1;
  localparam int A_LED2_BIT = 3;
  localparam int ST_CROWBAR_BIT = 0;
  // led mode codes
  localparam logic [1:0] LMODE_HW1 = 2'h1;
  localparam logic [1:0] LMODE_HW2 = 2'h2;
  // led state codes
  localparam logic [2:0] LS_OFF = 3'h0;
  localparam logic [2:0] LS_ON = 3'h1;
  localparam logic [2:0] LS_B1HZ = 3'h2;
  localparam logic [2:0] LS_B2HZ = 3'h3;
  localparam logic [2:0] LS_BHALF = 3'h4;
  localparam logic [2:0] LS_BQTR = 3'h5;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int TMO_BASE_MS = 500;
  localparam int TMO_STEP_MS = 250;
  localparam int TMO_STEP_CYC = TMO_STEP_MS * (CLK_HZ / 1000);
  localparam int BLINK_HALF_MS = 125;
  localparam int BLINK_TICK_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int PWB_PULSE_MS = 100;
  localparam int PWB_PULSE_CYC = PWB_PULSE_MS * (CLK_HZ / 1000);
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CB_IDLE = 2'b00,
    CB_COUNT = 2'b01,
    CB_TRIP = 2'b11
  } scl_cb_t;
endpackage

// ### core/scl_top.sv
`timescale 1ns/1ps
// Overview of operation
// - supply-on asserted while supply inactive starts the crowbar timer
// - terminal count before supply active flags crowbar, drops supply-on, forces off
// - crowbar timeout 0.5 to 2.25 s from register D bits 4-3
// - crowbar pulses the power-button output toward the power controller
// - register D bit 0 selects ACPI mode (1) or legacy mode (0)
// - two LED outputs, enabled by register A bits 1-2 and bit 3
// - register D bit 7 sets the active level of both LEDs
// - register B bits 3-2 select software, hardware 1 or hardware 2 LED mode
// - register C: LED1 state bits 0-2, LED2 state bits 3-5
// - with main and standby power, LEDs follow software unless hardware mode overrides
// - hardware 1 after standby reset: LED1 off, LED2 blinks 1 Hz half duty
// - hardware 1, ACPI mode, main power absent: LED1 software, LED2 blinks 1 Hz
// - hardware mode, ACPI and sleep 3: both LEDs follow software
// - hardware 2, ACPI, sleep 5, C bit 6 and supply control: software LEDs
// - hardware 2, any other ACPI configuration: both LEDs off
// - legacy mode with main power absent: hardware modes force LEDs off
// - two straps sampled at standby reset; unconnected straps read zero
// - straps 00 ctl, 01 LED2, 10 none, 11 ctl and LED2
// - write-one-to-clear bits clear on one, unchanged on zero
// - split registers: read returns one register, write updates another
// - registers occupy indexes 20h-25h, 27h, 28h, 2Ah-2Dh, 30h and 31h; 2Eh reserved and unused
// - chip identity register is read-only, fixed identity code
module scl_top #(
  parameter int TMO_STEP_CYCLES = scl_pkg::TMO_STEP_CYC,
  parameter int BLINK_TICK_CYCLES = scl_pkg::BLINK_TICK_CYC,
  parameter int PWB_PULSE_CYCLES = scl_pkg::PWB_PULSE_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [9:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [9:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic supply_led_strap0_i,
  input wire logic supply_led_strap1_i,
  input wire logic sleep_s3_i,
  input wire logic sleep_s5_i,
  input wire logic supply_ok_i,
  input wire logic main_power_i,
  input wire logic supply_on_req_i,
  output logic supply_on_output_o,
  output logic power_button_output_n_o,
  output logic led1_o,
  output logic led2_o,
  output logic supply_controller_en_o
);
  import scl_pkg::*;

  localparam int TMO_W = $clog2((4 * TMO_BASE_MS / TMO_STEP_MS + 8) * TMO_STEP_CYCLES);
  localparam int BLK_W = $clog2(BLINK_TICK_CYCLES + 1);
  localparam int PWB_W = $clog2(PWB_PULSE_CYCLES + 1);

  // elaboration guard: zero counts stall the dividers, oversized steps overflow the timer math
  if (TMO_STEP_CYCLES < 1 || TMO_STEP_CYCLES > 100_000_000 || BLINK_TICK_CYCLES < 1
      || PWB_PULSE_CYCLES < 1) begin : g_param_check
    $error("scl_top: cycle count parameter out of range");
  end

  // timeout steps: 0.5 s base plus 0.25 s per code step gives 0.5..1.0 s; code 3 gives 2.25 s
  function automatic logic [TMO_W-1:0] tmo_cycles(input logic [1:0] code);
    int unsigned steps;
    steps = (code == 2'h3) ? 9 : 2 + code;
    return TMO_W'(steps * TMO_STEP_CYCLES);
  endfunction

  // blink pattern lookup from a shared divider phase
  function automatic logic led_pattern(input logic [2:0] st, input logic [3:0] ph);
    case (st)
      LS_OFF: led_pattern = 1'b0;
      LS_ON: led_pattern = 1'b1;
      LS_B1HZ: led_pattern = ph[2];
      LS_B2HZ: led_pattern = ph[1];
      LS_BHALF: led_pattern = ph[3];
      LS_BQTR: led_pattern = ph[3] & ph[2];
      default: led_pattern = 1'b0;
    endcase
  endfunction

  logic [7:0] cfg1_q, cfg2_q, cfg3_q, cfg4_q, cfg5_q, cfg8_q;
  logic [7:0] cfga_q, cfgb_q, cfgc_q, cfgd_q;
  logic crowbar_flag_q;
  logic strap_done_q, psc_en_q, led2_sel_q;
  logic after_reset_q;
  logic aw_full_q, w_full_q;
  logic [7:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [7:0] ar_idx;
  logic rd_hit;
  logic [7:0] rd_byte;
  scl_cb_t cb_state_q;
  logic [TMO_W-1:0] cb_cnt_q;
  logic [BLK_W-1:0] blk_cnt_q;
  logic [3:0] blk_ph_q;
  logic [PWB_W-1:0] pwb_cnt_q;
  logic trip;
  logic lock;
  logic led1_raw, led2_raw;

  assign lock = cfg1_q[7];
  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid_o;
  assign trip = (cb_state_q == CB_COUNT) && (cb_cnt_q == 0) && !supply_ok_i;

  // straps caught once after reset release; pull-downs make open straps read zero
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_done_q <= 1'b0;
      psc_en_q <= 1'b0;
      led2_sel_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      psc_en_q <= supply_led_strap0_i ~^ supply_led_strap1_i;
      led2_sel_q <= supply_led_strap1_i;
    end
  end

  // axi write address and data captured independently, in either order
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_idx_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr_i[9:2];
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // ready only while the holding slot is empty, so a pending write cannot be overrun
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_full_q && !(s_axi_awvalid_i && s_axi_awready_o);
      s_axi_wready_o <= !w_full_q && !(s_axi_wvalid_i && s_axi_wready_o);
    end
  end

  // write response; unmapped or read-only index answers slave error
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      case (aw_idx_q)
        IDX_CFG1, IDX_CFG2, IDX_CFG3, IDX_CFG4, IDX_CFG5, IDX_CFG8,
        IDX_CFGA, IDX_CFGB, IDX_CFGC, IDX_CFGD, IDX_STATUS: s_axi_bresp_o <= RESP_OKAY;
        default: s_axi_bresp_o <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // configuration registers; pin-function bits freeze once the lock bit is set
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg1_q <= CFG1_RST;
      cfg2_q <= CFG_RST;
      cfg3_q <= CFG_RST;
      cfg4_q <= CFG_RST;
      cfg5_q <= CFG_RST;
      cfg8_q <= CFG_RST;
      cfga_q <= CFG_RST;
      cfgb_q <= CFG_RST;
      cfgc_q <= CFG_RST;
      cfgd_q <= CFGD_RST;
    end else if (wr_fire && wstrb_q[0]) begin
      case (aw_idx_q)
        IDX_CFG1: cfg1_q <= {wdata_q[7] | lock, wdata_q[6:2], 1'b0, wdata_q[0]}; // soft reset reads 0
        IDX_CFG2: if (!lock) cfg2_q <= wdata_q[7:0];
        IDX_CFG3: if (!lock) cfg3_q <= wdata_q[7:0];
        IDX_CFG4: if (!lock) cfg4_q <= wdata_q[7:0];
        IDX_CFG5: if (!lock) cfg5_q <= wdata_q[7:0];
        IDX_CFG8: cfg8_q <= wdata_q[7:0];
        IDX_CFGA: if (!lock) cfga_q <= wdata_q[7:0];
        IDX_CFGB: if (!lock) cfgb_q <= wdata_q[7:0];
        IDX_CFGC: cfgc_q <= wdata_q[7:0];
        IDX_CFGD: cfgd_q <= wdata_q[7:0];
        default: ;
      endcase
    end
  end

  // crowbar flag: hardware set wins over a same-cycle one-to-clear
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      crowbar_flag_q <= 1'b0;
    end else if (trip) begin
      crowbar_flag_q <= 1'b1;
    end else if (wr_fire && wstrb_q[0] && aw_idx_q == IDX_STATUS
                 && wdata_q[ST_CROWBAR_BIT]) begin
      crowbar_flag_q <= 1'b0;
    end
  end

  // read decode: status index reads the flag, writes of one to it clear (split behaviour)
  always_comb begin
    ar_idx = s_axi_araddr_i[9:2];
    rd_hit = 1'b1;
    case (ar_idx)
      IDX_CHIP_ID: rd_byte = CHIP_ID_VAL;
      IDX_CFG1: rd_byte = cfg1_q;
      IDX_CFG2: rd_byte = cfg2_q;
      IDX_CFG3: rd_byte = cfg3_q;
      IDX_CFG4: rd_byte = cfg4_q;
      IDX_CFG5: rd_byte = cfg5_q;
      IDX_REV: rd_byte = CHIP_REV_VAL;
      IDX_CFG8: rd_byte = cfg8_q;
      IDX_CFGA: rd_byte = cfga_q;
      IDX_CFGB: rd_byte = cfgb_q;
      IDX_CFGC: rd_byte = cfgc_q;
      IDX_CFGD: rd_byte = cfgd_q;
      IDX_STATUS: rd_byte = {7'h00, crowbar_flag_q};
      IDX_SYSCTL: rd_byte = {5'h00, led2_sel_q, psc_en_q, supply_on_output_o};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read channel: accept one address, answer on the next edge
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h000000, rd_byte};
      s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o) begin
      if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end else begin
      s_axi_arready_o <= 1'b1;
    end
  end

  // crowbar timer loads on supply-on with supply still down and counts down
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cb_state_q <= CB_IDLE;
      cb_cnt_q <= '0;
    end else begin
      case (cb_state_q)
        CB_IDLE: if (supply_on_output_o && !supply_ok_i) begin
          cb_state_q <= CB_COUNT;
          cb_cnt_q <= tmo_cycles(cfgd_q[D_TMO_LO +: 2]);
        end
        CB_COUNT: if (!supply_on_output_o || supply_ok_i) begin
          cb_state_q <= CB_IDLE;
          cb_cnt_q <= '0;
        end else if (trip) begin
          cb_state_q <= CB_TRIP;
        end else begin
          cb_cnt_q <= cb_cnt_q - 1'b1;
        end
        CB_TRIP: if (!supply_on_req_i) begin
          cb_state_q <= CB_IDLE; // rearm only after the request falls, avoids retrip loop
        end
        default: cb_state_q <= CB_IDLE;
      endcase
    end
  end

  // supply-on follows the request only when the straps enable supply control (psc_en_q), forced low while tripped
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      supply_on_output_o <= 1'b0;
      supply_controller_en_o <= 1'b0;
    end else begin
      supply_controller_en_o <= psc_en_q;
      supply_on_output_o <= psc_en_q && supply_on_req_i && !trip
                            && cb_state_q != CB_TRIP;
    end
  end

  // power-button pulse, active low, fired by a crowbar trip
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwb_cnt_q <= '0;
      power_button_output_n_o <= 1'b1;
    end else if (trip) begin
      pwb_cnt_q <= PWB_W'(PWB_PULSE_CYCLES);
      power_button_output_n_o <= 1'b0;
    end else if (pwb_cnt_q != 0) begin
      pwb_cnt_q <= pwb_cnt_q - 1'b1;
      power_button_output_n_o <= (pwb_cnt_q == 1);
    end
  end

  // free-running blink divider; phase bit 2 toggles every 0.5 s for a 1 Hz square
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blk_cnt_q <= '0;
      blk_ph_q <= 4'h0;
    end else if (blk_cnt_q == BLK_W'(BLINK_TICK_CYCLES - 1)) begin
      blk_cnt_q <= '0;
      blk_ph_q <= blk_ph_q + 1'b1;
    end else begin
      blk_cnt_q <= blk_cnt_q + 1'b1;
    end
  end

  // remembers the post-reset window until software first writes register C
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      after_reset_q <= 1'b1;
    end else if (wr_fire && aw_idx_q == IDX_CFGC) begin
      after_reset_q <= 1'b0;
    end
  end

  // led source selection; hardware modes override software state
  always_comb begin
    logic sw1, sw2, acpi;
    logic [1:0] lm;
    sw1 = led_pattern(cfgc_q[C_LED1_LO +: 3], blk_ph_q);
    sw2 = led_pattern(cfgc_q[C_LED2_LO +: 3], blk_ph_q);
    acpi = cfgd_q[D_MODE_BIT];
    lm = cfgb_q[B_LMODE_LO +: 2];
    led1_raw = sw1;
    led2_raw = sw2;
    if (lm == LMODE_HW1 || lm == LMODE_HW2) begin
      if (acpi && sleep_s3_i) begin
        led1_raw = sw1;
        led2_raw = sw2;
      end else if (!acpi && !main_power_i) begin
        led1_raw = 1'b0;
        led2_raw = 1'b0;
      end else if (lm == LMODE_HW1) begin
        led1_raw = after_reset_q ? 1'b0 : sw1;
        led2_raw = blk_ph_q[2];
      end else if (acpi && sleep_s5_i && cfgc_q[C_S5SW_BIT] && psc_en_q) begin
        led1_raw = sw1;
        led2_raw = sw2;
      end else if (acpi) begin
        led1_raw = 1'b0;
        led2_raw = 1'b0;
      end
    end
  end

  // pin enable and polarity applied at the flops; disabled pins sit inactive
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      led1_o <= 1'b0;
      led2_o <= 1'b0;
    end else begin
      led1_o <= ((cfga_q[A_LED1_LO +: 2] != 2'h0) & led1_raw) ^ ~cfgd_q[D_POL_BIT];
      led2_o <= (cfga_q[A_LED2_BIT] & led2_sel_q & led2_raw) ^ ~cfgd_q[D_POL_BIT];
    end
  end

endmodule

// ### dv/scl_supply_model.sv
`timescale 1ns/1ps
module scl_supply_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic supply_on_i,
  input wire logic pwb_n_i,
  input wire logic want_on_i,
  input wire logic slow_i,
  output logic supply_ok_o,
  output logic supply_on_req_o
);
  logic [1:0] dly_q;
  logic block_q;
  // supply answers three cycles after turn-on; a dead supply never does
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_q <= 2'h0;
      supply_ok_o <= 1'b0;
    end else begin
      dly_q <= !supply_on_i ? 2'h0 : (dly_q == 2'h3) ? dly_q : dly_q + 2'h1;
      supply_ok_o <= supply_on_i && !slow_i && dly_q >= 2'h2;
    end
  end
  // controller: a button pulse sends it to off until software lets go
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      block_q <= 1'b0;
      supply_on_req_o <= 1'b0;
    end else begin
      block_q <= want_on_i && (block_q || !pwb_n_i);
      supply_on_req_o <= want_on_i && !block_q && pwb_n_i;
    end
  end
endmodule

// ### dv/scl_top_asserts.sv
`timescale 1ns/1ps
module scl_top_asserts #(
  parameter int TMO_STEP_CYCLES = scl_pkg::TMO_STEP_CYC,
  parameter int PWB_PULSE_CYCLES = scl_pkg::PWB_PULSE_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic supply_ok_i,
  input wire logic supply_on_req_i,
  input wire logic supply_on_output_o,
  input wire logic power_button_output_n_o,
  input wire logic supply_controller_en_o
);
  int on_cnt_q;
  int pwb_cnt_q;
  // cycles powered with no supply answer, and width of the button pulse
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      on_cnt_q <= 0;
      pwb_cnt_q <= 0;
    end else begin
      on_cnt_q <= (supply_on_output_o && !supply_ok_i) ? on_cnt_q + 1 : 0;
      pwb_cnt_q <= power_button_output_n_o ? 0 : pwb_cnt_q + 1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  // output dropped although the request still stood, so only a crowbar explains it
  sequence s_trip;
    $fell(supply_on_output_o) && $past(supply_on_req_i);
  endsequence
  sequence s_pulse_end;
    $rose(power_button_output_n_o);
  endsequence
  AST_TRIP_PWB: assert property (s_trip |-> ##[0:2] !power_button_output_n_o)
    else $error("crowbar without power button pulse");
  AST_PWB_LEN: assert property (s_pulse_end |-> pwb_cnt_q == PWB_PULSE_CYCLES)
    else $error("power button pulse width wrong");
  AST_PWB_MAX: assert property (pwb_cnt_q <= PWB_PULSE_CYCLES)
    else $error("power button pulse too long");
  AST_TRIP_MIN: assert property (s_trip |-> on_cnt_q >= 2 * TMO_STEP_CYCLES - 3)
    else $error("crowbar before shortest timeout");
  AST_TRIP_MAX: assert property (on_cnt_q <= 9 * TMO_STEP_CYCLES + 3)
    else $error("no crowbar after longest timeout");
  AST_OK_HOLDS: assert property (supply_on_output_o && supply_ok_i && supply_on_req_i
    |=> supply_on_output_o)
    else $error("supply dropped while supply active");
  AST_ON_NEEDS_REQ: assert property (supply_on_output_o
    |-> $past(supply_on_req_i) && supply_controller_en_o)
    else $error("supply on without request or enable");
  AST_EN_STABLE: assert property ($past(reset_n_i, 3) |-> $stable(supply_controller_en_o))
    else $error("strap decode changed after sampling");
endmodule
bind scl_top scl_top_asserts #(
  .TMO_STEP_CYCLES(TMO_STEP_CYCLES),
  .PWB_PULSE_CYCLES(PWB_PULSE_CYCLES)
) u_asserts (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .supply_ok_i(supply_ok_i),
  .supply_on_req_i(supply_on_req_i), .supply_on_output_o(supply_on_output_o),
  .power_button_output_n_o(power_button_output_n_o),
  .supply_controller_en_o(supply_controller_en_o));

// ### dv/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  import scl_pkg::*;
  localparam int TS = 4;
  localparam int BT = 2;
  localparam int PW = 3;
  localparam int HALF = (1000 / 2 / BLINK_HALF_MS) * BT;
  logic core_clk = 1'b0, reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, strap0 = 1'b0, strap1 = 1'b0, s3 = 1'b0, s5 = 1'b0;
  logic mainp = 1'b0, want = 1'b0, slow = 1'b0;
  logic [9:0] awaddr = 10'h0, araddr = 10'h0;
  logic [31:0] wdata = 32'h0, seed = 32'hB2AE1074;
  logic awready, wready, bvalid, arready, rvalid, supply_on, pwb_n, led1, led2, en, ok, req;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_total = 0, cmp_count = 0;
  logic [7:0] ridx [13] = '{IDX_CHIP_ID, IDX_CFG1, IDX_CFG2, IDX_CFG3, IDX_CFG4, IDX_CFG5,
    IDX_CFG8, IDX_CFGA, IDX_CFGB, IDX_CFGC, IDX_REV, IDX_CFGD, IDX_STATUS};
  logic [7:0] rexp [13] = '{CHIP_ID_VAL, CFG1_RST, CFG_RST, CFG_RST, CFG_RST, CFG_RST,
    CFG_RST, CFG_RST, CFG_RST, CFG_RST, CHIP_REV_VAL, CFGD_RST, 8'h00};
  // led cases: mode reg, supply reg, s3, s5, main power, led1, led2
  logic [20:0] lc [7] = '{{8'h00, 8'h81, 5'b00111}, {8'h00, 8'h01, 5'b00100},
    {8'h08, 8'h81, 5'b00100}, {8'h08, 8'h81, 5'b01111}, {8'h04, 8'h81, 5'b10111},
    {8'h08, 8'h81, 5'b10111}, {8'h08, 8'h80, 5'b00000}};
  scl_top #(.TMO_STEP_CYCLES(TS), .BLINK_TICK_CYCLES(BT), .PWB_PULSE_CYCLES(PW)) u_dut (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .supply_led_strap0_i(strap0), .supply_led_strap1_i(strap1),
    .sleep_s3_i(s3), .sleep_s5_i(s5), .supply_ok_i(ok), .main_power_i(mainp),
    .supply_on_req_i(req), .supply_on_output_o(supply_on), .power_button_output_n_o(pwb_n),
    .led1_o(led1), .led2_o(led2), .supply_controller_en_o(en));
  scl_supply_model u_psu (.clk_i(core_clk), .rst_n_i(reset_n), .supply_on_i(supply_on),
    .pwb_n_i(pwb_n), .want_on_i(want), .slow_i(slow), .supply_ok_o(ok), .supply_on_req_o(req));
  // free-running 10 MHz clock
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // timeout codes 0-2 step a quarter second from half a second, code 3 is 2.25 s
  function automatic int tmo(input int k);
    return ((k == 3) ? 9 : k + 2) * TS;
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rst(input logic a, input logic b);
    reset_n <= 1'b0;
    strap0 <= a;
    strap1 <= b;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic wchk(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    bit a, w;
    int n;
    a = 0;
    w = 0;
    n = 0;
    @(posedge core_clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (1) begin
      @(posedge core_clk);
      n++;
      if (!a && awready) begin a = 1; awvalid <= 1'b0; end
      if (!w && wready) begin w = 1; wvalid <= 1'b0; end
      if (bvalid) begin `CHK("bresp", er, bresp) bready <= 1'b0; break; end
      if (n > 50) begin err_total++; conclude(); end
    end
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (1) begin
      @(posedge core_clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin `CHK("rdata", {24'h0, e}, rdata) `CHK("rresp", er, rresp) break; end
      if (n > 50) begin err_total++; conclude(); end
    end
    rready <= 1'b0;
  endtask
  // a faster or slower blink shows in the toggle count, a skewed duty in the high count
  task automatic blink();
    int c, t;
    logic p;
    c = 0;
    t = 0;
    p = led2;
    repeat (8 * HALF) begin
      @(posedge core_clk);
      c += int'(led2 === 1'b1);
      t += int'(led2 !== p);
      p = led2;
    end
    `CHK("blink", 1'b1, c >= 4 * HALF - 2 && c <= 4 * HALF + 2 && t >= 7 && t <= 9)
  endtask
  // main sequence: straps, registers, leds, crowbar
  initial begin
    int n;
    for (int s = 0; s < 4; s++) begin
      rst(s[1], s[0]);
      `CHK("ctl_en", s[1] == s[0], en)
      rchk(IDX_SYSCTL, {5'h0, s[0], s[1] == s[0], 1'b0}, RESP_OKAY);
      if (s == 0) begin
        for (int i = 0; i < 13; i++) rchk(ridx[i], rexp[i], RESP_OKAY);
        rchk(8'h2E, 8'h00, RESP_SLVERR);
        wchk(IDX_CHIP_ID, 8'hFF, RESP_SLVERR);
        rchk(IDX_CHIP_ID, CHIP_ID_VAL, RESP_OKAY);
        for (int i = 0; i < 16; i++) begin
          seed = xs(seed);
          wchk(ridx[2 + i % 8], seed[7:0], RESP_OKAY);
          rchk(ridx[2 + i % 8], seed[7:0], RESP_OKAY);
        end
      end
    end
    wchk(IDX_CFGA, 8'h0E, RESP_OKAY);
    wchk(IDX_CFGD, 8'h81, RESP_OKAY);
    wchk(IDX_CFGB, 8'h04, RESP_OKAY);
    mainp <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK("led1", 1'b0, led1)
    blink();
    wchk(IDX_CFGC, 8'h49, RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      {s3, s5, mainp} <= lc[i][4:2];
      wchk(IDX_CFGD, lc[i][12:5], RESP_OKAY);
      wchk(IDX_CFGB, lc[i][20:13], RESP_OKAY);
      repeat (3) @(posedge core_clk);
      `CHK("leds", lc[i][1:0], {led1, led2})
    end
    wchk(IDX_CFGB, 8'h00, RESP_OKAY);
    wchk(IDX_CFGC, {2'b01, LS_B1HZ, LS_ON}, RESP_OKAY);
    blink();
    {s3, s5, mainp} <= 3'h0;
    wchk(IDX_CFGD, 8'h81, RESP_OKAY);
    wchk(IDX_CFGB, 8'h04, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    `CHK("led1", 1'b1, led1)
    blink();
    slow <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      wchk(IDX_CFGD, 8'(8'h81 | (k << 3)), RESP_OKAY);
      want <= 1'b1;
      n = 0;
      while (!supply_on && n < 20) begin @(posedge core_clk); n++; end
      if (n >= 20) begin err_total++; conclude(); end
      n = 0;
      while (supply_on && n < 100) begin @(posedge core_clk); n++; end
      if (n >= 100) begin err_total++; conclude(); end
      `CHK("timeout", 1'b1, n >= tmo(k) - 3 && n <= tmo(k) + 3)
      rchk(IDX_STATUS, 8'h01, RESP_OKAY);
      wchk(IDX_STATUS, 8'h00, RESP_OKAY);
      rchk(IDX_STATUS, 8'h01, RESP_OKAY);
      wchk(IDX_STATUS, 8'h01, RESP_OKAY);
      rchk(IDX_STATUS, 8'h00, RESP_OKAY);
      want <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    slow <= 1'b0;
    want <= 1'b1;
    repeat (100) @(posedge core_clk);
    `CHK("supply_on", 1'b1, supply_on)
    rchk(IDX_STATUS, 8'h00, RESP_OKAY);
    want <= 1'b0;
    conclude();
  end
endmodule
